// ==== common/analog_io_diag_consts.svh ====
`ifndef ANALOG_IO_DIAG_CONSTS_SVH
`define ANALOG_IO_DIAG_CONSTS_SVH

// record geometry
`define DIAG_ADDR_W        4
`define DIAG_RECORD_BYTES  12
`define DIAG_SUMMARY_BYTES 4

// byte offsets inside the extended record
`define OFS_SUMMARY_FLAGS  4'h0
`define OFS_MODULE_CLASS   4'h1
`define OFS_RESERVED_A     4'h2
`define OFS_RESERVED_B     4'h3
`define OFS_CHANNEL_TYPE   4'h4
`define OFS_BITS_PER_CH    4'h5
`define OFS_CHANNEL_COUNT  4'h6
`define OFS_CHANNEL_ERRORS 4'h7
`define OFS_INPUT_CH01     4'h8
`define OFS_INPUT_CH23     4'h9
`define OFS_OUTPUT_CH45    4'hA
`define OFS_RESERVED_C     4'hB

// reset and fixed values
`define RST_SUMMARY_FLAGS  8'h00
`define RST_MODULE_CLASS   8'h15
`define VAL_CLASS_ANALOG   4'h5
`define VAL_CHANNEL_TYPE   7'h74
`define VAL_BITS_PER_CH    8'h04
`define VAL_CHANNEL_COUNT  8'h06
`define VAL_RESERVED       8'h00

// summary byte 0 bit positions
`define B0_MODULE_FAULT    0
`define B0_EXTERNAL_ERROR  2
`define B0_CHANNEL_ERROR   3
`define B0_SUPPLY_MISSING  4
`define B0_BAD_PARAMS      7
// summary byte 1 bit position
`define B1_CHANNEL_INFO    4
// parameter byte 0 bit that enables the diagnostic report
`define P0_DIAG_INT_EN     6

// measured value scaling
`define SCALE_FULL         32'sd27648
`define SCALE_U_SPAN_MV    32'sd4000
`define SCALE_I_OFS_UA     32'sd4000
`define SCALE_I_SPAN_UA    32'sd16000

`endif

// ==== common/analog_io_diag_pkg.sv ====
`default_nettype none
package analog_io_diag_pkg;
  // report sender states, gray along idle -> send -> idle
  typedef enum logic [0:0] {
    RPT_IDLE = 1'b0,
    RPT_SEND = 1'b1
  } rpt_state_e;

  // measuring range selected for the scaler
  typedef enum logic [0:0] {
    RANGE_PM4V   = 1'b0,
    RANGE_4_20MA = 1'b1
  } range_mode_e;
endpackage
`default_nettype wire

// ==== src/range_scaler.sv ====
`include "analog_io_diag_consts.svh"
`default_nettype none
module range_scaler (
  // clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         rst_n,
  // raw sample: millivolts or microamps
  input  wire logic                         sample_valid,
  input  wire analog_io_diag_pkg::range_mode_e mode,
  input  wire logic signed [31:0]           sample_raw,
  // scaled value
  output var  logic                         value_valid,
  output var  logic signed [15:0]           value
);
  logic signed [31:0] next_value;

  ////////////////////////////////////////////////////////////////////////////
  // scaling; constant divisors let synthesis fold the divide
  always_comb begin
    if (mode == analog_io_diag_pkg::RANGE_PM4V) begin
      next_value = (`SCALE_FULL * sample_raw) / `SCALE_U_SPAN_MV;
    end else begin
      next_value = (`SCALE_FULL * (sample_raw - `SCALE_I_OFS_UA)) / `SCALE_I_SPAN_UA;
    end
  end

  // result register, one cycle after the sample
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      value_valid <= 1'b0;
      value       <= 16'sh0000;
    end else begin
      value_valid <= sample_valid;
      if (sample_valid) begin
        value <= next_value[15:0]; // overdrive limits keep it in 16 bits
      end
    end
  end
endmodule
`default_nettype wire

// ==== src/diag_report_tx.sv ====
`include "analog_io_diag_consts.svh"
`default_nettype none
module diag_report_tx (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // report request and the summary to send
  input  wire logic        start,
  input  wire logic [31:0] summary,
  // byte stream toward the controller
  input  wire logic        rpt_ready,
  output var  logic        rpt_valid,
  output var  logic [7:0]  rpt_data,
  output var  logic        rpt_last,
  output var  logic        busy
);
  analog_io_diag_pkg::rpt_state_e state;
  logic [31:0] shadow;
  logic [1:0]  idx;
  logic        pending;
  logic        take;
  logic        done;

  assign take = rpt_valid && rpt_ready;
  assign done = take && rpt_last;

  ////////////////////////////////////////////////////////////////////////////
  // a request during a send is held, set beating the clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pending <= 1'b0;
    end else if (start && (state == analog_io_diag_pkg::RPT_SEND)) begin
      pending <= 1'b1;
    end else if (state == analog_io_diag_pkg::RPT_IDLE) begin
      pending <= 1'b0;
    end
  end

  // sender: snapshot then four bytes, byte 0 first
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state     <= analog_io_diag_pkg::RPT_IDLE;
      shadow    <= 32'h0000_0000;
      idx       <= 2'h0;
      rpt_valid <= 1'b0;
      rpt_data  <= 8'h00;
      rpt_last  <= 1'b0;
    end else begin
      case (state)
        analog_io_diag_pkg::RPT_IDLE: begin
          if (start || pending) begin
            state     <= analog_io_diag_pkg::RPT_SEND;
            shadow    <= summary;
            idx       <= 2'h1;
            rpt_valid <= 1'b1;
            rpt_data  <= summary[7:0];
            rpt_last  <= 1'b0;
          end
        end
        analog_io_diag_pkg::RPT_SEND: begin
          if (done) begin
            state     <= analog_io_diag_pkg::RPT_IDLE;
            rpt_valid <= 1'b0;
            rpt_last  <= 1'b0;
          end else if (take) begin
            rpt_data <= shadow[8*idx +: 8];
            rpt_last <= (idx == 2'(`DIAG_SUMMARY_BYTES - 1));
            idx      <= idx + 2'h1;
          end
        end
        default: begin
          state     <= analog_io_diag_pkg::RPT_IDLE;
          rpt_valid <= 1'b0;
        end
      endcase
    end
  end

  assign busy = (state == analog_io_diag_pkg::RPT_SEND);
endmodule
`default_nettype wire

// ==== src/analog_io_diag_records.sv ====
`include "analog_io_diag_consts.svh"
`default_nettype none
module analog_io_diag_records #(
  parameter int NUM_IN  = 4,
  parameter int NUM_OUT = 2
) (
  // clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         rst_n,
  // record read port
  input  wire logic                         rd_en,
  input  wire logic [`DIAG_ADDR_W-1:0]      rd_addr,
  output var  logic                         rd_ack,
  output var  logic [7:0]                   rd_data,
  // module level conditions
  input  wire logic                         module_fault,
  input  wire logic                         external_error,
  input  wire logic                         supply_missing_pin,
  input  wire logic                         bad_params,
  // parameter byte 0
  input  wire logic [7:0]                   param_byte0,
  // input channel conditions
  input  wire logic [NUM_IN-1:0]            in_wire_break,
  input  wire logic [NUM_IN-1:0]            in_param_error,
  input  wire logic [NUM_IN-1:0]            in_underflow,
  input  wire logic [NUM_IN-1:0]            in_overflow,
  // output channel conditions
  input  wire logic [NUM_OUT-1:0]           out_wire_short,
  input  wire logic [NUM_OUT-1:0]           out_param_error,
  // summary report toward the controller
  input  wire logic                         rpt_ready,
  output var  logic                         rpt_valid,
  output var  logic [7:0]                   rpt_data,
  output var  logic                         rpt_last,
  // measured value scaling
  input  wire logic                         sample_valid,
  input  wire analog_io_diag_pkg::range_mode_e range_mode,
  input  wire logic signed [31:0]           sample_raw,
  output var  logic                         value_valid,
  output var  logic signed [15:0]           value
);
  localparam int NUM_CH = NUM_IN + NUM_OUT;

  ////////////////////////////////////////////////////////////////////////////
  // the byte layout only serves four inputs and two outputs
  if (NUM_IN != 4 || NUM_OUT != 2) begin : g_bad_geometry
    $error("channel counts must be four inputs and two outputs");
  end

  ////////////////////////////////////////////////////////////////////////////
  // supply sense comes from a pin, so synchronise it first
  logic supply_meta;
  logic supply_sync;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      supply_meta <= 1'b0;
      supply_sync <= 1'b0;
    end else begin
      supply_meta <= supply_missing_pin;
      supply_sync <= supply_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per channel error: any of its flags
  logic [NUM_CH-1:0] next_ch_err;

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch_err
    if (c < NUM_IN) begin : g_in
      assign next_ch_err[c] = in_wire_break[c] | in_param_error[c]
                            | in_underflow[c] | in_overflow[c];
    end else begin : g_out
      assign next_ch_err[c] = out_wire_short[c-NUM_IN] | out_param_error[c-NUM_IN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // record bytes; fixed ones are constants, the rest track conditions
  logic [7:0] summary_flags;
  logic [7:0] module_class;
  logic [7:0] channel_errors;
  logic [7:0] input_ch01;
  logic [7:0] input_ch23;
  logic [7:0] output_ch45;
  logic [7:0] next_summary_flags;
  logic [7:0] next_input_ch01;
  logic [7:0] next_input_ch23;
  logic [7:0] next_output_ch45;

  // summary byte 0 composition
  always_comb begin
    next_summary_flags = `VAL_RESERVED;
    next_summary_flags[`B0_MODULE_FAULT]   = module_fault;
    next_summary_flags[`B0_EXTERNAL_ERROR] = external_error;
    next_summary_flags[`B0_CHANNEL_ERROR]  = |next_ch_err;
    next_summary_flags[`B0_SUPPLY_MISSING] = supply_sync;
    next_summary_flags[`B0_BAD_PARAMS]     = bad_params;
  end

  // input nibbles: wire break, param, underflow, overflow, even channel low
  always_comb begin
    next_input_ch01 = {in_overflow[1], in_underflow[1], in_param_error[1], in_wire_break[1],
                       in_overflow[0], in_underflow[0], in_param_error[0], in_wire_break[0]};
    next_input_ch23 = {in_overflow[3], in_underflow[3], in_param_error[3], in_wire_break[3],
                       in_overflow[2], in_underflow[2], in_param_error[2], in_wire_break[2]};
  end

  // output byte, reserved pairs held at zero
  always_comb begin
    next_output_ch45 = {2'b00, out_param_error[1], out_wire_short[1],
                        2'b00, out_param_error[0], out_wire_short[0]};
  end

  // summary record registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      summary_flags <= `RST_SUMMARY_FLAGS;
      module_class  <= `RST_MODULE_CLASS;
    end else begin
      summary_flags <= next_summary_flags;
      module_class  <= {3'b000, 1'b1, `VAL_CLASS_ANALOG};
    end
  end

  // module specific registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      channel_errors <= `VAL_RESERVED;
      input_ch01     <= `VAL_RESERVED;
      input_ch23     <= `VAL_RESERVED;
      output_ch45    <= `VAL_RESERVED;
    end else begin
      channel_errors <= {2'b00, next_ch_err};
      input_ch01     <= next_input_ch01;
      input_ch23     <= next_input_ch23;
      output_ch45    <= next_output_ch45;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: twelve bytes, summary first, then module bytes
  logic [7:0] next_rd_data;

  always_comb begin
    case (rd_addr)
      `OFS_SUMMARY_FLAGS:  next_rd_data = summary_flags;
      `OFS_MODULE_CLASS:   next_rd_data = module_class;
      `OFS_RESERVED_A:     next_rd_data = `VAL_RESERVED;
      `OFS_RESERVED_B:     next_rd_data = `VAL_RESERVED;
      `OFS_CHANNEL_TYPE:   next_rd_data = {1'b0, `VAL_CHANNEL_TYPE};
      `OFS_BITS_PER_CH:    next_rd_data = `VAL_BITS_PER_CH;
      `OFS_CHANNEL_COUNT:  next_rd_data = `VAL_CHANNEL_COUNT;
      `OFS_CHANNEL_ERRORS: next_rd_data = channel_errors;
      `OFS_INPUT_CH01:     next_rd_data = input_ch01;
      `OFS_INPUT_CH23:     next_rd_data = input_ch23;
      `OFS_OUTPUT_CH45:    next_rd_data = output_ch45;
      `OFS_RESERVED_C:     next_rd_data = `VAL_RESERVED;
      default:             next_rd_data = `VAL_RESERVED; // past the record
    endcase
  end

  // read data register, answered one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_ack  <= 1'b0;
      rd_data <= 8'h00;
    end else begin
      rd_ack <= rd_en;
      if (rd_en) begin
        rd_data <= next_rd_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error detection: any summary, channel error or input nibble bit that was clear and is now set; output byte bits are not compared
  logic [7:0]  cond_prev_sum;
  logic [23:0] cond_prev_ch;
  logic        new_error;
  logic        report_start;

  assign new_error = |(summary_flags & ~cond_prev_sum)
                   | |({channel_errors, input_ch01, input_ch23} & ~cond_prev_ch);

  // compared on registered bytes so the report carries the fresh state
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cond_prev_sum <= 8'h00;
      cond_prev_ch  <= 24'h00_0000;
    end else begin
      cond_prev_sum <= summary_flags;
      cond_prev_ch  <= {channel_errors, input_ch01, input_ch23};
    end
  end

  // only raised errors report; clearing a condition sends nothing
  assign report_start = new_error && param_byte0[`P0_DIAG_INT_EN];

  diag_report_tx u_report (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .start     (report_start),
    .summary   ({`VAL_RESERVED, `VAL_RESERVED, module_class, summary_flags}),
    .rpt_ready (rpt_ready),
    .rpt_valid (rpt_valid),
    .rpt_data  (rpt_data),
    .rpt_last  (rpt_last),
    .busy      ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // measured value scaling
  range_scaler u_scaler (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .sample_valid (sample_valid),
    .mode         (range_mode),
    .sample_raw   (sample_raw),
    .value_valid  (value_valid),
    .value        (value)
  );
endmodule
`default_nettype wire

// ==== verification/analog_io_diag_records_chk.sv ====
`include "analog_io_diag_consts.svh"
`default_nettype none
module analog_io_diag_records_chk (
  // clock and reset
  input wire logic                    clk_sys,
  input wire logic                    rst_n,
  // record read port
  input wire logic                    rd_en,
  input wire logic [`DIAG_ADDR_W-1:0] rd_addr,
  input wire logic                    rd_ack,
  input wire logic [7:0]              rd_data,
  // report stream
  input wire logic                    rpt_ready,
  input wire logic                    rpt_valid,
  input wire logic [7:0]              rpt_data,
  input wire logic                    rpt_last,
  // scaler strobes
  input wire logic                    sample_valid,
  input wire logic                    value_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // bytes taken so far in the report; position decides what may be sent
  logic [1:0] taken;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || (rpt_valid && rpt_ready && rpt_last))
      taken <= 2'h0;
    else if (rpt_valid && rpt_ready)
      taken <= taken + 2'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  a_read_ack: assert property (rd_en |=> rd_ack) else $error("read not acknowledged");
  a_ack_spurious: assert property (!rd_en |=> !rd_ack) else $error("ack without read");
  a_class_byte: assert property (rd_en && rd_addr == 4'h1 |=> rd_data == 8'h15) else $error("class byte");
  a_type_code: assert property (rd_en && rd_addr == 4'h4 |=> rd_data == 8'h74) else $error("type code");
  a_bits_per_ch: assert property (rd_en && rd_addr == 4'h5 |=> rd_data == 8'h04) else $error("bits per ch");
  a_channel_count: assert property (rd_en && rd_addr == 4'h6 |=> rd_data == 8'h06) else $error("count");
  a_rsvd_err_bits: assert property (rd_en && rd_addr == 4'h7 |=> rd_data[7:6] == 2'h0) else $error("b7");
  a_rsvd_out_bits: assert property (rd_en && rd_addr == 4'hA |=> (rd_data & 8'hCC) == 8'h00)
    else $error("byte 10 reserved bits set");
  a_reserved_bytes: assert property (rd_en && (rd_addr == 4'h2 || rd_addr == 4'h3 || rd_addr >= 4'hB)
    |=> rd_data == 8'h00) else $error("reserved byte not zero");
  a_byte_hold: assert property (rpt_valid && !rpt_ready |=> rpt_valid && $stable(rpt_data) && $stable(rpt_last))
    else $error("report byte dropped before taken");
  a_last_fourth: assert property (rpt_valid |-> rpt_last == (taken == 2'h3)) else $error("last misplaced");
  a_second_byte: assert property (rpt_valid && taken == 2'h1 |-> rpt_data == 8'h15) else $error("byte 1");
  a_pad_bytes: assert property (rpt_valid && taken[1] |-> rpt_data == 8'h00) else $error("pad byte");
  a_value_strobe: assert property (sample_valid |=> value_valid) else $error("no scaled value");
  // main scenarios seen
  c_report_end: cover property (rpt_valid && rpt_ready && rpt_last);
  c_report_stall: cover property (rpt_valid && !rpt_ready);
  c_error_read: cover property (rd_en && rd_addr == 4'h7);
endmodule
`default_nettype wire

// ==== verification/report_sink.sv ====
`default_nettype none
module report_sink (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // stall control
  input  wire logic       stall_en,
  // report stream
  input  wire logic       rpt_valid,
  input  wire logic [7:0] rpt_data,
  input  wire logic       rpt_last,
  output var  logic       rpt_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0]  got[$];
  logic [15:0] lfsr;
  // controller side: takes bytes, stalls at random when asked
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      lfsr <= 16'hACE1;
      rpt_ready <= 1'b0;
    end else begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      rpt_ready <= stall_en ? lfsr[0] : 1'b1;
      if (rpt_valid && rpt_ready)
        got.push_back({rpt_last, rpt_data});
    end
  end
endmodule
`default_nettype wire

// ==== verification/analog_io_diag_records_tb.sv ====
`include "analog_io_diag_consts.svh"
`default_nettype none
module analog_io_diag_records_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                            clk_sys, rst_n, rd_en, rd_ack, rpt_ready, rpt_valid, rpt_last, stall_en;
  logic                            module_fault, external_error, supply_missing_pin, bad_params;
  logic                            sample_valid, value_valid, m;
  logic [3:0]                      rd_addr, in_wire_break, in_param_error, in_underflow, in_overflow;
  logic [1:0]                      out_wire_short, out_param_error;
  logic [7:0]                      rd_data, rpt_data, param_byte0;
  logic [31:0]                     seed, r;
  logic signed [31:0]              sample_raw, raw;
  logic signed [15:0]              value;
  analog_io_diag_pkg::range_mode_e range_mode;
  int                              n_fail, comparisons;
  ////////////////////////////////////////////////////////////////////////////
  analog_io_diag_records uut (.clk_sys(clk_sys), .rst_n(rst_n), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_ack(rd_ack), .rd_data(rd_data), .module_fault(module_fault), .external_error(external_error),
    .supply_missing_pin(supply_missing_pin), .bad_params(bad_params), .param_byte0(param_byte0),
    .in_wire_break(in_wire_break), .in_param_error(in_param_error), .in_underflow(in_underflow),
    .in_overflow(in_overflow), .out_wire_short(out_wire_short), .out_param_error(out_param_error),
    .rpt_ready(rpt_ready), .rpt_valid(rpt_valid), .rpt_data(rpt_data), .rpt_last(rpt_last),
    .sample_valid(sample_valid), .range_mode(range_mode), .sample_raw(sample_raw),
    .value_valid(value_valid), .value(value));
  report_sink peer (.clk_sys(clk_sys), .rst_n(rst_n), .stall_en(stall_en), .rpt_valid(rpt_valid),
    .rpt_data(rpt_data), .rpt_last(rpt_last), .rpt_ready(rpt_ready));
  // 10 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////
  // xorshift keeps every run identical
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // record byte expected from the condition levels now applied
  function automatic logic [7:0] exp_byte(input logic [3:0] a);
    logic [5:0] ce;
    ce = {out_wire_short | out_param_error, in_wire_break | in_param_error | in_underflow | in_overflow};
    case (a)
      4'h0: return {bad_params, 2'h0, supply_missing_pin, |ce, external_error, 1'b0, module_fault};
      4'h1: return 8'h15;
      4'h4: return 8'h74;
      4'h5: return 8'h04;
      4'h6: return 8'h06;
      4'h7: return {2'h0, ce};
      4'h8: return {in_overflow[1], in_underflow[1], in_param_error[1], in_wire_break[1],
                    in_overflow[0], in_underflow[0], in_param_error[0], in_wire_break[0]};
      4'h9: return {in_overflow[3], in_underflow[3], in_param_error[3], in_wire_break[3],
                    in_overflow[2], in_underflow[2], in_param_error[2], in_wire_break[2]};
      4'hA: return {2'h0, out_param_error[1], out_wire_short[1], 2'h0, out_param_error[0], out_wire_short[0]};
      default: return 8'h00;
    endcase
  endfunction
  // signed divide truncates toward zero, as the scaler does
  function automatic logic signed [15:0] exp_value(input logic md, input logic signed [31:0] s);
    longint v;
    v = md ? (longint'(27648) * (s - 4000)) / 16000 : (longint'(27648) * s) / 4000;
    return 16'(v);
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wrap_up();
    if (n_fail == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // inputs always move 10 ns after the rising edge
  task tick();
    @(posedge clk_sys);
    #10;
  endtask
  task set_conds(input logic [31:0] c);
    {module_fault, external_error, supply_missing_pin, bad_params} = c[3:0];
    {in_wire_break, in_param_error, in_underflow, in_overflow} = c[19:4];
    {out_wire_short, out_param_error} = c[23:20];
  endtask
  // back-to-back reads of all sixteen addresses
  task dump();
    for (int a = 0; a < 16; a++) begin
      rd_en = 1'b1;
      rd_addr = 4'(a);
      tick();
      chk({15'h0, rd_ack, rd_data}, {15'h1, exp_byte(4'(a))});
    end
    rd_en = 1'b0;
  endtask
  task wait_bytes(input int n);
    for (int i = 0; i < 300 && peer.got.size() < n; i++)
      tick();
    if (peer.got.size() < n) begin
      n_fail++;
      wrap_up();
    end
  endtask
  task chk_report(input int base, input logic [7:0] b0);
    for (int i = 0; i < 4; i++)
      chk({15'h0, peer.got[base + i]}, {15'h0, i == 3, i == 0 ? b0 : exp_byte(4'(i))});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'd18396;
    n_fail = 0;
    comparisons = 0;
    {rst_n, rd_en, rd_addr, param_byte0, sample_valid, sample_raw, stall_en} = '0;
    range_mode = analog_io_diag_pkg::RANGE_PM4V;
    set_conds(32'h0);
    repeat (6) tick();
    rst_n = 1'b1;
    chk({rpt_valid, rd_ack, value_valid, rpt_last, rd_data, value[11:0]}, 24'h0);
    dump();
    // random condition mixes with the report off, then all flags at once
    repeat (24) begin
      set_conds(rnd());
      param_byte0 = 8'(rnd()) & 8'hBF;
      repeat (5) tick();
      dump();
    end
    set_conds(32'hFFFFFF);
    repeat (5) tick();
    dump();
    // report with a stalling controller; second error arrives mid-send
    set_conds(32'h0);
    repeat (5) tick();
    peer.got.delete();
    param_byte0 = 8'h40;
    stall_en = 1'b1;
    tick();
    module_fault = 1'b1;
    tick();
    tick();
    in_wire_break = 4'h2;
    wait_bytes(8);
    repeat (20) tick();
    chk(24'(peer.got.size()), 24'd8);
    chk_report(0, 8'h01);
    chk_report(4, exp_byte(4'h0));
    // report enable clear: a new error stays silent
    param_byte0 = 8'h00;
    peer.got.delete();
    bad_params = 1'b1;
    repeat (20) tick();
    chk(24'(peer.got.size()), 24'd0);
    // scaler: eight fixed samples (4000 to -2000 mV, 4000 to 12000 uA) then random in-range samples, back to back
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      m = i < 8 ? (i >= 4) : r[0];
      raw = i < 8 ? 32'(i < 4 ? 2000 * (2 - i) : 4000 * (i - 3) - 4000 * (i == 7) - 1 * (i == 7)) :
            (m ? 32'(4000 + int'(r[31:1] % 16001)) : 32'(int'(r[31:1] % 8001) - 4000));
      sample_valid = 1'b1;
      range_mode = analog_io_diag_pkg::range_mode_e'(m);
      sample_raw = raw;
      tick();
      chk({7'h0, value_valid, value}, {7'h1, exp_value(m, raw)});
    end
    sample_valid = 1'b0;
    wrap_up();
  end
endmodule
bind analog_io_diag_records analog_io_diag_records_chk chk (.clk_sys(clk_sys), .rst_n(rst_n), .rd_en(rd_en),
  .rd_addr(rd_addr), .rd_ack(rd_ack), .rd_data(rd_data), .rpt_ready(rpt_ready), .rpt_valid(rpt_valid),
  .rpt_data(rpt_data), .rpt_last(rpt_last), .sample_valid(sample_valid), .value_valid(value_valid));
`default_nettype wire
